/* File: logic/dmt_tone_ordering_gain_scaler.sv */
// Tone ordering bit loader, label FIFO and per-tone gain scaler.
`timescale 1ns/100ps

module label_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Next pointers and occupancy, shared by the bookkeeping and the head.
  wire [AW-1:0] wr_inc = (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
  wire [AW-1:0] rd_inc = (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
  wire [AW-1:0] next_rd_idx = pop ? rd_inc : rd_idx;
  wire [AW:0] next_count =
    count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // A word written into the slot that becomes the head skips the array,
  // so the registered head never shows a stale word after an empty spell.
  wire head_bypass = push && (next_rd_idx == wr_idx);
  wire [WIDTH-1:0] next_head = head_bypass ? in_data : mem[next_rd_idx];

  // Ready follows the count; valid and data leave from flip-flops.
  assign in_ready = (count != FULL_CNT);

  // Pointer, occupancy and head register bookkeeping.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_idx <= wr_inc;
      end
      rd_idx <= next_rd_idx;
      count <= next_count;
      out_valid <= (next_count != '0);
      out_data <= next_head;
    end
  end

  // Storage needs no reset; reads are gated by the count.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end
endmodule

// Operation
// - Multiply each encoded point of a tone by that tone's gain, 0.75 to 1.33.
// - With dual latency, interleaved bits land on the highest SNR tones.
// - Fast bits fill fewest-bit tones first, interleaved bits fill the rest.
// - Each tone carries exactly its bit count; boundary tones mix both buffers.
// - Order table sweeps k from 0 to maximum, ascending tone index per k.
// - Single latency loads tones in frequency order from the original table.
// - Fast bits are taken from the LSB onto the smallest-count tone.
// - Amateur band tones are suppressed unless management enables them.
// - Per-direction bit maximum lies within 8 to 15 and bounds the sweep.
module dmt_tone_ordering_gain_scaler (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sym_valid,
  output logic sym_ready,
  input wire tone_order_pkg::sym_t sym_in,
  input wire logic [tone_order_pkg::N_TONES-1:0][3:0] bit_table,
  input wire logic [3:0] bmax_sel,
  input wire logic dual_latency,
  input wire logic [tone_order_pkg::N_TONES-1:0] ham_band,
  input wire logic [tone_order_pkg::N_TONES-1:0] ham_enable,
  input wire logic [tone_order_pkg::N_TONES-1:0][7:0] gain_table,
  output logic lbl_valid,
  input wire logic lbl_ready,
  output tone_order_pkg::lbl_t lbl_out,
  input wire logic pt_valid,
  input wire tone_order_pkg::pt_t pt_in,
  output logic spt_valid,
  output tone_order_pkg::spt_t spt_out
);
  tone_order_pkg::state_t state;
  tone_order_pkg::state_t next_state;
  logic [tone_order_pkg::STREAM_W-1:0] stream;
  logic [tone_order_pkg::TONE_W-1:0] order_tab [tone_order_pkg::N_TONES];
  logic [tone_order_pkg::TONE_W-1:0] tone_idx;
  logic [tone_order_pkg::TONE_W-1:0] wr_pos;
  logic [tone_order_pkg::BITS_W-1:0] sweep_k;
  logic [tone_order_pkg::PTR_W-1:0] bit_ptr;
  logic single_mode;
  logic [tone_order_pkg::N_TONES-1:0][3:0] eff_bits;

  // The bit maximum is held inside the legal span before it bounds the sweep.
  wire [3:0] bmax_eff = (bmax_sel < tone_order_pkg::BMAX_LO) ?
    tone_order_pkg::BMAX_LO : bmax_sel;

  // Per-tone effective bit counts: masked amateur tones carry nothing.
  genvar gi;
  generate
    for (gi = 0; gi < tone_order_pkg::N_TONES; gi++) begin : g_eff
      wire muted = ham_band[gi] && !ham_enable[gi];
      wire [3:0] capped = (bit_table[gi] > bmax_eff) ?
        bmax_eff : bit_table[gi];
      assign eff_bits[gi] = muted ? 4'h0 : capped;
    end
  endgenerate

  // Fast bits sit at the bottom of the stream, interleaved bits above them.
  wire [tone_order_pkg::BUF_W-1:0] fast_mask =
    ~({tone_order_pkg::BUF_W{1'b1}} << sym_in.fast_cnt);
  wire [tone_order_pkg::STREAM_W-1:0] fast_part =
    {{tone_order_pkg::BUF_W{1'b0}}, sym_in.fast & fast_mask};
  wire [tone_order_pkg::STREAM_W-1:0] intl_part =
    {{tone_order_pkg::BUF_W{1'b0}}, sym_in.intl} << sym_in.fast_cnt;
  wire [tone_order_pkg::STREAM_W-1:0] next_stream = fast_part | intl_part;
  wire sym_take = sym_valid && sym_ready;

  // Sweep decode: ordered mode matches count k, single mode takes every tone.
  wire sweep_hit = single_mode ||
    (eff_bits[tone_idx] == sweep_k);
  wire sweep_last_tone = (tone_idx == tone_order_pkg::TONE_LAST);
  wire sweep_done = sweep_last_tone &&
    (single_mode || (sweep_k == bmax_eff));

  // Load decode: next tone in order and its exact bit count.
  wire fifo_in_ready;
  wire [tone_order_pkg::TONE_W-1:0] load_tone = order_tab[tone_idx];
  wire [3:0] load_bits = eff_bits[load_tone];
  wire [tone_order_pkg::STREAM_W-1:0] shifted = stream >> bit_ptr;
  wire [tone_order_pkg::LBL_W-1:0] lbl_mask =
    ~({tone_order_pkg::LBL_W{1'b1}} << load_bits);
  wire [tone_order_pkg::LBL_W-1:0] lbl_bits =
    shifted[tone_order_pkg::LBL_W-1:0] & lbl_mask;
  wire load_push = (state == tone_order_pkg::ST_LOAD);
  wire load_step = load_push && fifo_in_ready;
  wire load_done = load_step && sweep_last_tone;
  tone_order_pkg::lbl_t push_lbl;

  assign push_lbl.tone = load_tone;
  assign push_lbl.nbits = load_bits;
  assign push_lbl.label = lbl_bits;

  // Next state of the controller.
  always_comb begin
    next_state = state;
    unique case (state)
      tone_order_pkg::ST_IDLE: begin
        if (sym_take) begin
          next_state = tone_order_pkg::ST_ORDER;
        end
      end
      tone_order_pkg::ST_ORDER: begin
        if (sweep_done) begin
          next_state = tone_order_pkg::ST_LOAD;
        end
      end
      tone_order_pkg::ST_LOAD: begin
        if (load_done) begin
          next_state = tone_order_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = tone_order_pkg::ST_IDLE;
      end
    endcase
  end

  // State register and input handshake.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= tone_order_pkg::ST_IDLE;
      sym_ready <= 1'b0;
    end else begin
      state <= next_state;
      sym_ready <= (next_state == tone_order_pkg::ST_IDLE);
    end
  end

  // Symbol capture; the mode is frozen for the whole symbol.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stream <= '0;
      single_mode <= 1'b0;
    end else if (sym_take) begin
      stream <= next_stream;
      single_mode <= !dual_latency;
    end
  end

  // Tone and bit-count counters of the sweep, reused as load position.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tone_idx <= '0;
      sweep_k <= '0;
    end else if (sym_take) begin
      tone_idx <= '0;
      sweep_k <= '0;
    end else if (state == tone_order_pkg::ST_ORDER) begin
      tone_idx <= tone_idx + 1'b1;
      if (sweep_last_tone) begin
        sweep_k <= sweep_k + 1'b1;
      end
    end else if (load_step) begin
      tone_idx <= tone_idx + 1'b1;
    end
  end

  // Appends matching tones to the order table in ascending index.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pos <= '0;
    end else if (sym_take) begin
      wr_pos <= '0;
    end else if (state == tone_order_pkg::ST_ORDER && sweep_hit) begin
      wr_pos <= wr_pos + 1'b1;
    end
  end

  // Order table storage; every tone is written once per symbol.
  always_ff @(posedge sys_clk) begin
    if (state == tone_order_pkg::ST_ORDER && sweep_hit) begin
      order_tab[wr_pos] <= tone_idx;
    end
  end

  // Bit pointer walks fast bits first, then interleaved bits.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_ptr <= '0;
    end else if (sym_take) begin
      bit_ptr <= '0;
    end else if (load_step) begin
      bit_ptr <= bit_ptr + {4'h0, load_bits};
    end
  end

  // Label FIFO toward the encoder; a full FIFO stalls the loader.
  label_fifo #(
    .WIDTH($bits(tone_order_pkg::lbl_t)),
    .DEPTH(tone_order_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(load_push),
    .in_ready(fifo_in_ready),
    .in_data(push_lbl),
    .out_valid(lbl_valid),
    .out_ready(lbl_ready),
    .out_data(lbl_out)
  );

  // Gain lookup, held inside the fine adjustment span.
  wire [7:0] gain_raw = gain_table[pt_in.tone];
  wire [7:0] gain_lo = (gain_raw < tone_order_pkg::GAIN_LO) ?
    tone_order_pkg::GAIN_LO : gain_raw;
  wire [7:0] gain_use = (gain_lo > tone_order_pkg::GAIN_HI) ?
    tone_order_pkg::GAIN_HI : gain_lo;
  wire signed [8:0] gain_s = {1'b0, gain_use};
  wire signed [tone_order_pkg::PROD_W-1:0] prod_x = pt_in.x * gain_s;
  wire signed [tone_order_pkg::PROD_W-1:0] prod_y = pt_in.y * gain_s;
  wire pt_mute = ham_band[pt_in.tone] && !ham_enable[pt_in.tone];
  wire [tone_order_pkg::SPT_W-1:0] sx =
    prod_x[tone_order_pkg::GAIN_FRAC +: tone_order_pkg::SPT_W];
  wire [tone_order_pkg::SPT_W-1:0] sy =
    prod_y[tone_order_pkg::GAIN_FRAC +: tone_order_pkg::SPT_W];

  // Scaled point register; muted tones send a zero point.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spt_valid <= 1'b0;
      spt_out <= '0;
    end else begin
      spt_valid <= pt_valid;
      if (pt_valid) begin
        spt_out.tone <= pt_in.tone;
        spt_out.x <= pt_mute ? '0 : sx;
        spt_out.y <= pt_mute ? '0 : sy;
      end
    end
  end
endmodule

/* File: logic/tone_order_pkg.sv */
// Shared constants, types and carriers for the tone ordering datapath.
package tone_order_pkg;
  localparam int N_TONES = 16;
  localparam int TONE_W = 4;
  localparam int BITS_W = 4;
  localparam int BUF_W = 128;
  localparam int STREAM_W = 256;
  localparam int PTR_W = 8;
  localparam int LBL_W = 15;
  localparam int GAIN_W = 8;
  localparam int GAIN_FRAC = 7;
  localparam int PT_W = 16;
  localparam int SPT_W = 17;
  localparam int PROD_W = PT_W + GAIN_W + 1;
  localparam int FIFO_DEPTH = 4;
  localparam logic [BITS_W-1:0] BMAX_LO = 4'h8;
  localparam logic [BITS_W-1:0] BMAX_HI = 4'hF;
  localparam logic [GAIN_W-1:0] GAIN_LO = 8'h60;
  localparam logic [GAIN_W-1:0] GAIN_HI = 8'hAA;
  localparam logic [TONE_W-1:0] TONE_LAST = 4'hF;

  // Controller states, Gray coded along idle, order, load.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ORDER = 2'b01,
    ST_LOAD = 2'b11
  } state_t;

  // One symbol's worth of framed data from the two buffers.
  typedef struct packed {
    logic [BUF_W-1:0] fast;
    logic [BUF_W-1:0] intl;
    logic [PTR_W-1:0] fast_cnt;
  } sym_t;

  // Bits handed to the constellation encoder for one tone.
  typedef struct packed {
    logic [TONE_W-1:0] tone;
    logic [BITS_W-1:0] nbits;
    logic [LBL_W-1:0] label;
  } lbl_t;

  // Encoded point returned by the constellation encoder.
  typedef struct packed {
    logic [TONE_W-1:0] tone;
    logic signed [PT_W-1:0] x;
    logic signed [PT_W-1:0] y;
  } pt_t;

  // Gain scaled point toward the modulator.
  typedef struct packed {
    logic [TONE_W-1:0] tone;
    logic signed [SPT_W-1:0] x;
    logic signed [SPT_W-1:0] y;
  } spt_t;
endpackage

/* File: tb/dmt_checker_assertions.sv */
// Port level checks for the tone loader and gain scaler.
`timescale 1ns/100ps
module dmt_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sym_valid,
  input wire logic sym_ready,
  input wire logic [15:0][3:0] bit_table,
  input wire logic [3:0] bmax_sel,
  input wire logic [15:0] ham_band,
  input wire logic [15:0] ham_enable,
  input wire logic [15:0][7:0] gain_table,
  input wire logic lbl_valid,
  input wire logic lbl_ready,
  input wire tone_order_pkg::lbl_t lbl_out,
  input wire logic pt_valid,
  input wire tone_order_pkg::pt_t pt_in,
  input wire logic spt_valid,
  input wire tone_order_pkg::spt_t spt_out
);
  // Bit maximum, raw count and mute state of the label tone, and mute state of the point tone.
  wire logic [3:0] bm = bmax_sel < tone_order_pkg::BMAX_LO ?
    tone_order_pkg::BMAX_LO : bmax_sel;
  wire logic [3:0] bt = bit_table[lbl_out.tone];
  wire logic lm = ham_band[lbl_out.tone] & ~ham_enable[lbl_out.tone];
  wire logic pm = ham_band[pt_in.tone] & ~ham_enable[pt_in.tone];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_take; sym_valid && sym_ready; endsequence
  sequence s_pt; pt_valid && !pm; endsequence
  property p_busy; s_take |=> !sym_ready [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_lat; pt_valid |=> spt_valid && spt_out.tone == $past(pt_in.tone);
  endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_idle; !pt_valid |=> !spt_valid; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_mute; pt_valid && pm |=> spt_out.x == 0 && spt_out.y == 0;
  endproperty
  a_mute: assert property (p_mute) else $error("mute");
  property p_unity; s_pt ##0 gain_table[pt_in.tone] == 8'h80
    |=> spt_out.x == $past(pt_in.x) && spt_out.y == $past(pt_in.y); endproperty
  a_unity: assert property (p_unity) else $error("unity");
  property p_hold; lbl_valid && !lbl_ready |=> lbl_valid && $stable(lbl_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_nbits;
    lbl_valid |-> lbl_out.nbits == (lm ? 4'h0 : (bt > bm ? bm : bt));
  endproperty
  a_nbits: assert property (p_nbits) else $error("count");
  property p_upper; lbl_valid |-> (lbl_out.label >> lbl_out.nbits) == 15'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper");
endmodule

/* File: tb/framer_model.sv */
// Framing side model that offers one symbol per go request.
`timescale 1ns/100ps
module framer_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire tone_order_pkg::sym_t sym_src,
  input wire logic sym_ready,
  output logic sym_valid = 1'b0,
  output tone_order_pkg::sym_t sym_in = '0
);
  // Holds the offer until taken, then scrambles the released lines.
  always @(posedge sys_clk) begin
    if (sym_valid && sym_ready) begin
      sym_valid <= 1'b0;
      sym_in <= ~sym_in;
    end else if (go && !sym_valid) begin
      sym_valid <= 1'b1;
      sym_in <= sym_src;
    end
  end
endmodule

/* File: tb/tb_dmt_tone_ordering_gain_scaler.sv */
// Self-checking bench for the tone loader and gain scaler.
`timescale 1ns/100ps
module tb_dmt_tone_ordering_gain_scaler;
  logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, lbl_ready = 1'b0;
  logic pt_valid = 1'b0, dual_latency = 1'b0;
  logic sym_valid, sym_ready, lbl_valid, spt_valid;
  logic [3:0] bmax_sel = 4'hF;
  logic [15:0] ham_band = 16'h0, ham_enable = 16'h0;
  logic [15:0][3:0] bit_table = '0;
  logic [15:0][7:0] gain_table = '0;
  tone_order_pkg::sym_t sym_src = '0, sym_in;
  tone_order_pkg::lbl_t lbl_out;
  tone_order_pkg::pt_t pt_in = '0;
  tone_order_pkg::spt_t spt_out;
  int failures = 0, cmp_count = 0;
  dmt_tone_ordering_gain_scaler dmt_tone_ordering_gain_scaler_inst (
    .sys_clk(sys_clk), .nrst(nrst), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .sym_in(sym_in), .bit_table(bit_table),
    .bmax_sel(bmax_sel), .dual_latency(dual_latency), .ham_band(ham_band),
    .ham_enable(ham_enable), .gain_table(gain_table),
    .lbl_valid(lbl_valid), .lbl_ready(lbl_ready), .lbl_out(lbl_out),
    .pt_valid(pt_valid), .pt_in(pt_in), .spt_valid(spt_valid),
    .spt_out(spt_out)
  );
  framer_model framer_model_inst (
    .sys_clk(sys_clk), .go(go), .sym_src(sym_src), .sym_ready(sym_ready),
    .sym_valid(sym_valid), .sym_in(sym_in)
  );
  // Free running 25 MHz clock.
  initial forever #20 sys_clk = ~sys_clk;
  task report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one label or one scaled point.
  task chk_lbl(input tone_order_pkg::lbl_t g, input tone_order_pkg::lbl_t e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_spt(input logic [38:0] g, input logic [38:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Offers a symbol, stalls the encoder, then checks every label.
  task run_sym(input int stall);
    logic [255:0] s;
    logic [3:0] bm, c;
    tone_order_pkg::lbl_t q, e[$];
    int p, w;
    p = 0;
    w = 0;
    bm = bmax_sel < 4'h8 ? 4'h8 : bmax_sel;
    s = {128'h0, sym_src.fast} & ((256'h1 << sym_src.fast_cnt) - 256'h1);
    s = s | ({128'h0, sym_src.intl} << sym_src.fast_cnt);
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 16; i++) begin
        c = bit_table[i] > bm ? bm : bit_table[i];
        if (ham_band[i] && !ham_enable[i]) c = 4'h0;
        if (dual_latency ? c == 4'(k) : i == k) begin
          q.tone = 4'(i);
          q.nbits = c;
          q.label = 15'(s >> p) & ((15'h1 << q.nbits) - 15'h1);
          p = p + int'(q.nbits);
          e.push_back(q);
        end
      end
    end
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    repeat (stall) @(negedge sys_clk);
    lbl_ready = 1'b1;
    while (e.size() > 0) begin
      if (lbl_valid === 1'b1) chk_lbl(lbl_out, e.pop_front());
      @(negedge sys_clk);
      w++;
      if (w > 3000) begin
        failures++;
        break;
      end
    end
    lbl_ready = 1'b0;
  endtask
  // Frequency order with muted and enabled amateur band tones.
  task t_single;
    dual_latency = 1'b0;
    bmax_sel = 4'hF;
    ham_band = 16'h00F0;
    ham_enable = 16'h0030;
    for (int i = 0; i < 16; i++) bit_table[i] = 4'(i);
    sym_src = {128'h0123456789ABCDEFFEDCBA9876543210, {4{32'h5A3C96E1}}, 8'h25};
    run_sym(0);
  endtask
  // Ordered sweep with capped counts and a full label queue.
  task t_ordered;
    dual_latency = 1'b1;
    bmax_sel = 4'h3;
    ham_band = 16'h0300;
    ham_enable = 16'h0100;
    for (int i = 0; i < 16; i++) bit_table[i] = 4'((i * 7 + 3) % 16);
    sym_src = {{4{32'hC3A50F69}}, 128'h89ABCDEF0123456776543210FEDCBA98, 8'h2B};
    run_sym(300);
  endtask
  // Back-to-back points across clamped, unity and muted gains.
  task t_gain;
    logic signed [24:0] m, n;
    logic [7:0] g;
    tone_order_pkg::pt_t pp;
    tone_order_pkg::spt_t e;
    ham_band = 16'h0050;
    ham_enable = 16'h0010;
    gain_table = 128'h7080_90FF_10AA_6080;
    for (int i = 0; i < 9; i++) begin
      pp = pt_in;
      pt_valid = i < 8;
      pt_in.tone = 4'(i);
      pt_in.x = 16'h8123 + 16'(i) * 16'h1357;
      pt_in.y = -pt_in.x;
      if (i > 0) begin
        g = gain_table[pp.tone];
        g = g < 8'h60 ? 8'h60 : (g > 8'hAA ? 8'hAA : g);
        m = pp.x * $signed({1'b0, g});
        n = pp.y * $signed({1'b0, g});
        e = {pp.tone, m[23:7], n[23:7]};
        if (ham_band[pp.tone] && !ham_enable[pp.tone]) e = {pp.tone, 34'h0};
        chk_spt({spt_valid, spt_out}, {1'b1, e});
      end
      @(negedge sys_clk);
    end
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    t_single;
    t_ordered;
    t_gain;
    report_and_stop;
  end
endmodule

bind dmt_tone_ordering_gain_scaler dmt_checker dmt_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .sym_valid(sym_valid),
  .sym_ready(sym_ready), .bit_table(bit_table), .bmax_sel(bmax_sel),
  .ham_band(ham_band), .ham_enable(ham_enable), .gain_table(gain_table),
  .lbl_valid(lbl_valid), .lbl_ready(lbl_ready), .lbl_out(lbl_out),
  .pt_valid(pt_valid), .pt_in(pt_in), .spt_valid(spt_valid),
  .spt_out(spt_out)
);
